/* core/emb_ext_mem.sv */
// Notes on behaviour
// - reset clears mode status register
// - reset release, map low, no bus request: boot then run from ram zero
// - one shared 14-bit address bus and data bus for program and data
// - data bus two-way, 24 bits for program words, code and data alike
// - program accesses assert program select with write or read strobe
// - 16-bit program data writes take low byte from extension reg; reads fill it
// - map low puts 2K internal program ram at zero
// - map high: external from zero, internal ram at 0x3800, no boot
// - 0x0800..0x27ff goes to rom when window enabled, otherwise external
// - rom window cleared on reset unless both straps high, then set
// - program external accesses get 0..7 wait states, seven after reset
// - 64K byte boot space in eight pages; page bits and force bit
// - boot accesses get 0..7 wait states, seven after reset
// - boot reads one byte per access, three bytes make one word
// - boot access asserts boot select and read, data from D8..D15
// - top two data lines carry top two boot address bits
// - boot source high with map low boots from host port; low from bus
// - both straps high: rom on, start at 0x0800, no boot
// - map high source low starts external zero; after boot internal zero
// - data accesses use 14-bit address, D8..D23, data select with strobe
// - internal data ram at 0x3000, 0x3800..0x3fff control registers
// - bus requests honoured always, also in boot and reset
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// byte buffer between boot source and word packer
// ---------------------------------------------------------------
module emb_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [$clog2(DEPTH+1)-1:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = cnt_q != ($clog2(DEPTH+1))'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_ptr_q];
	assign count = cnt_q;

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ---------------------------------------------------------------
// external memory interface, memory map and boot loader
// ---------------------------------------------------------------
module emb_ext_mem #(
	parameter int BOOT_WORDS = emb_pkg::BOOT_WORDS,
	parameter int FIFO_DEPTH = emb_pkg::FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic memory_map_select,
	input wire logic boot_source_select,
	input wire logic bus_req_n,
	output logic bus_grant_n,
	output logic [13:0] ext_addr,
	input wire logic [23:0] ext_data_in,
	output logic [23:0] ext_data_out,
	output logic [23:0] ext_data_oe,
	output logic ext_ctrl_oe,
	output logic program_space_select_n,
	output logic data_space_select_n,
	output logic boot_space_select_n,
	output logic ext_rd_n,
	output logic ext_wr_n,
	input wire logic [7:0] host_byte,
	input wire logic host_byte_valid,
	output logic host_byte_ready,
	output logic [13:0] rom_addr,
	input wire logic [23:0] rom_word,
	input wire logic core_req,
	input wire logic core_pm,
	input wire logic core_we,
	input wire logic core_pm_data,
	input wire logic [13:0] core_addr,
	input wire logic [23:0] core_wdata,
	output logic core_ack,
	output logic [23:0] core_rdata,
	input wire logic px_we,
	input wire logic [7:0] px_wdata,
	output logic [7:0] low_byte_extension_reg,
	input wire logic mode_status_register_we,
	input wire logic [6:0] mode_status_register_wdata,
	output logic [6:0] mode_status_register,
	output logic core_hold,
	output logic run_start,
	output logic [13:0] run_addr,
	output logic rom_window_enable
);
	localparam int BOOT_BYTES = BOOT_WORDS * emb_pkg::BYTES_PER_WORD;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic memory_map_select_s1, memory_map_select_s2, boot_source_select_s1, boot_source_select_s2, breq_s1, breq_s2;
	logic [23:0] din_s1, din_s2;
	always_ff @(posedge core_clk) begin
		memory_map_select_s1 <= memory_map_select;
		memory_map_select_s2 <= memory_map_select_s1;
		boot_source_select_s1 <= boot_source_select;
		boot_source_select_s2 <= boot_source_select_s1;
		breq_s1 <= !bus_req_n;
		breq_s2 <= breq_s1;
		din_s1 <= ext_data_in;
		din_s2 <= din_s1;
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	emb_pkg::emb_state_t state_q;
	logic memory_map_select_q, host_boot_q, hold_q, start_q;
	logic [13:0] start_addr_q;
	logic [15:0] ctrl_q;
	logic [6:0] mode_status_register_q;
	logic [7:0] px_q;
	logic busy_q, kind_boot_q, push_q, rom_pend_q, ack_q, gnt_n_q, ctrl_oe_q, host_rdy_q;
	logic op_pm_q, op_pmd_q, op_we_q;
	logic [3:0] cnt_q;
	logic [13:0] addr_q, rom_addr_q;
	logic [23:0] dout_q, doe_q, rdata_q;
	logic pms_n_q, dms_n_q, bms_n_q, rd_n_q, wr_n_q;
	logic [7:0] push_byte_q;
	logic [12:0] fetch_cnt_q;
	logic [11:0] word_cnt_q;
	logic [1:0] pack_cnt_q;
	logic [15:0] pack_buf_q;
	logic [23:0] pack_word_q;
	logic pack_wr_q;
	logic [23:0] pram [0:2047];
	logic [15:0] dram [0:2047];

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire in_boot = state_q == emb_pkg::ST_BOOT;
	wire in_run = state_q == emb_pkg::ST_RUN;
	wire granted = !gnt_n_q;
	wire [2:0] pm_wait = ctrl_q[emb_pkg::PMW_LSB +: emb_pkg::WAIT_W];
	wire [2:0] dm_wait = ctrl_q[emb_pkg::DMW_LSB +: emb_pkg::WAIT_W];
	wire [2:0] bt_wait = ctrl_q[emb_pkg::BTW_LSB +: emb_pkg::WAIT_W];
	wire [2:0] page = ctrl_q[emb_pkg::PAGE_LSB +: emb_pkg::PAGE_W];
	wire [10:0] iidx = core_addr[10:0];
	wire pm_int = memory_map_select_q ? (core_addr >= emb_pkg::PRAM_HI_BASE)
		: (core_addr < emb_pkg::ROM_FIRST);
	wire pm_rom = ctrl_q[emb_pkg::ROMEN_BIT] && core_addr >= emb_pkg::ROM_FIRST
		&& core_addr <= emb_pkg::ROM_LAST;
	wire dm_ram = core_addr >= emb_pkg::DRAM_BASE && core_addr < emb_pkg::DREG_BASE;
	wire dm_reg = core_addr >= emb_pkg::DREG_BASE;
	wire go_ext = core_pm ? !(pm_int || pm_rom) : !(dm_ram || dm_reg);
	wire take = in_run && core_req && !busy_q && !rom_pend_q && !ack_q && !granted;
	wire [23:0] pm_wword = core_pm_data ? {core_wdata[15:0], px_q} : core_wdata;
	wire [15:0] dm_rd = dm_reg ? ((core_addr == emb_pkg::CTRL_REG_ADDR) ? ctrl_q : 16'h0000)
		: dram[iidx];
	wire ctrl_wr = take && !core_pm && core_we && core_addr == emb_pkg::CTRL_REG_ADDR;
	wire force_go = in_run && ctrl_q[emb_pkg::FORCE_BIT] && !core_req && !busy_q
		&& !rom_pend_q && !ack_q;

	// boot byte address: page in bits 15:13, top two bits go out on D22..D23
	wire [15:0] boot_addr = {page, 13'h0000} + {3'b000, fetch_cnt_q};
	wire fifo_in_ready, fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
	wire fetch_go = in_boot && !host_boot_q && !busy_q && !push_q && !granted
		&& fifo_in_ready && fetch_cnt_q < 13'(BOOT_BYTES);
	// host bytes are counted too, so no spare byte is left in the buffer after the last word
	wire host_push = host_boot_q && host_rdy_q && host_byte_valid;
	wire [12:0] fetch_cnt_d = fetch_cnt_q + {12'h000, fetch_go || host_push};
	wire ext_go = fetch_go || (take && go_ext);
	wire ext_done = busy_q && cnt_q == 4'h0;
	wire [2:0] go_wait = fetch_go ? bt_wait : (core_pm ? pm_wait : dm_wait);
	wire [23:0] go_oe = fetch_go ? emb_pkg::BOOT_OE : !core_we ? 24'h00_0000
		: core_pm ? 24'hff_ffff : emb_pkg::DM_OE;
	wire [23:0] go_dout = fetch_go ? {boot_addr[15:14], 22'h00_0000}
		: core_pm ? pm_wword : {core_wdata[15:0], 8'h00};
	wire fifo_in_valid = host_boot_q ? (host_rdy_q && host_byte_valid) : push_q;
	wire [7:0] fifo_in_data = host_boot_q ? host_byte : push_byte_q;
	wire fifo_out_ready = in_boot && !pack_wr_q;
	wire pop = fifo_out_valid && fifo_out_ready;
	wire boot_last = pack_wr_q && word_cnt_q == 12'(BOOT_WORDS - 1);

	emb_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_data(fifo_in_data),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.count(fifo_count)
	);

	// ---------------------------------------------------------------
	// sequencing: straps, boot, run
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		start_q <= 1'b0;
		if (sys_rst) begin
			state_q <= emb_pkg::ST_INIT;
			hold_q <= 1'b1;
			mode_status_register_q <= emb_pkg::MODE_STATUS_REGISTER_RESET;
			memory_map_select_q <= memory_map_select_s2;
			host_boot_q <= 1'b0;
			start_addr_q <= emb_pkg::START_RAM;
		end else begin
			if (mode_status_register_we)
				mode_status_register_q <= mode_status_register_wdata;
			case (state_q)
			emb_pkg::ST_INIT: begin
				if (!breq_s2) begin
					if (!memory_map_select_q) begin
						state_q <= emb_pkg::ST_BOOT;
						host_boot_q <= boot_source_select_s2;
					end else begin
						state_q <= emb_pkg::ST_RUN;
						hold_q <= 1'b0;
						start_q <= 1'b1;
						start_addr_q <= boot_source_select_s2 ? emb_pkg::START_ROM : emb_pkg::START_EXT;
					end
				end
			end
			emb_pkg::ST_BOOT: begin
				if (boot_last) begin
					state_q <= emb_pkg::ST_RUN;
					hold_q <= 1'b0;
					start_q <= 1'b1;
					start_addr_q <= emb_pkg::START_RAM;
					host_boot_q <= 1'b0;
				end
			end
			emb_pkg::ST_RUN: begin
				if (force_go) begin
					state_q <= emb_pkg::ST_BOOT;
					hold_q <= 1'b1;
					host_boot_q <= 1'b0;
				end
			end
			default: state_q <= emb_pkg::ST_INIT;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// control register and extension byte
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_q <= emb_pkg::CTRL_RESET;
			ctrl_q[emb_pkg::ROMEN_BIT] <= memory_map_select_s2 && boot_source_select_s2;
			px_q <= 8'h00;
		end else begin
			// a software write wins over the hardware clear of the force bit
			if (ctrl_wr)
				ctrl_q <= core_wdata[15:0];
			else if (force_go)
				ctrl_q[emb_pkg::FORCE_BIT] <= 1'b0;
			if (ack_q == 1'b0 && (rom_pend_q || (ext_done && !kind_boot_q))
				&& op_pm_q && op_pmd_q && !op_we_q)
				px_q <= rom_pend_q ? rom_word[7:0] : din_s2[7:0];
			else if (take && core_pm && pm_int && core_pm_data && !core_we)
				px_q <= pram[iidx][7:0];
			else if (px_we)
				px_q <= px_wdata;
		end
	end

	// ---------------------------------------------------------------
	// internal memories
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (pack_wr_q)
			pram[word_cnt_q[10:0]] <= pack_word_q;
		else if (take && core_pm && pm_int && core_we)
			pram[iidx] <= pm_wword;
		if (take && !core_pm && dm_ram && core_we)
			dram[iidx] <= core_wdata[15:0];
	end

	// ---------------------------------------------------------------
	// external bus engine; strobe spans wait + 3 cycles for the data sync
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			kind_boot_q <= 1'b0;
			cnt_q <= 4'h0;
			addr_q <= 14'h0000;
			dout_q <= 24'h00_0000;
			doe_q <= 24'h00_0000;
			{pms_n_q, dms_n_q, bms_n_q, rd_n_q, wr_n_q} <= 5'h1f;
		end else if (ext_go) begin
			busy_q <= 1'b1;
			kind_boot_q <= fetch_go;
			cnt_q <= {1'b0, go_wait} + emb_pkg::SYNC_EXTRA;
			addr_q <= fetch_go ? boot_addr[13:0] : core_addr;
			dout_q <= go_dout;
			doe_q <= go_oe;
			bms_n_q <= !fetch_go;
			pms_n_q <= !(!fetch_go && core_pm);
			dms_n_q <= !(!fetch_go && !core_pm);
			rd_n_q <= !(fetch_go || !core_we);
			wr_n_q <= !(!fetch_go && core_we);
		end else if (ext_done) begin
			busy_q <= 1'b0;
			doe_q <= 24'h00_0000;
			{pms_n_q, dms_n_q, bms_n_q, rd_n_q, wr_n_q} <= 5'h1f;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end

	// grant only between accesses; keeps working through reset and boot
	always_ff @(posedge core_clk) begin
		gnt_n_q <= !(breq_s2 && (granted || (!busy_q && !ext_go)));
		ctrl_oe_q <= !(breq_s2 && (granted || (!busy_q && !ext_go)));
	end

	// ---------------------------------------------------------------
	// boot byte fetch and word packing, msb byte first
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst || !in_boot) begin
			push_q <= 1'b0;
			push_byte_q <= 8'h00;
			fetch_cnt_q <= 13'h0000;
			word_cnt_q <= 12'h000;
			pack_cnt_q <= 2'b00;
			pack_buf_q <= 16'h0000;
			pack_word_q <= 24'h00_0000;
			pack_wr_q <= 1'b0;
			host_rdy_q <= 1'b0;
		end else begin
			push_q <= ext_done && kind_boot_q;
			push_byte_q <= din_s2[15:8];
			fetch_cnt_q <= fetch_cnt_d;
			host_rdy_q <= host_boot_q && fetch_cnt_d < 13'(BOOT_BYTES)
				&& fifo_count < ($clog2(FIFO_DEPTH+1))'(FIFO_DEPTH - 1);
			pack_wr_q <= pop && pack_cnt_q == 2'd2;
			if (pop) begin
				if (pack_cnt_q == 2'd2) begin
					pack_word_q <= {pack_buf_q, fifo_out_data};
					pack_cnt_q <= 2'b00;
				end else begin
					pack_buf_q <= {pack_buf_q[7:0], fifo_out_data};
					pack_cnt_q <= pack_cnt_q + 2'b01;
				end
			end
			if (pack_wr_q)
				word_cnt_q <= word_cnt_q + 12'h001;
		end
	end

	// ---------------------------------------------------------------
	// core answers
	// ---------------------------------------------------------------
	wire rd_int = take && !go_ext && !(core_pm && pm_rom);
	wire [23:0] f_word = rd_int ? (core_pm ? pram[iidx] : {dm_rd, 8'h00})
		: rom_pend_q ? rom_word : din_s2;
	wire f_pm = rd_int ? core_pm : op_pm_q;
	wire f_pmd = rd_int ? core_pm_data : op_pmd_q;
	wire fire = rd_int || rom_pend_q || (ext_done && !kind_boot_q);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
			rdata_q <= 24'h00_0000;
			rom_pend_q <= 1'b0;
			rom_addr_q <= 14'h0000;
			{op_pm_q, op_pmd_q, op_we_q} <= 3'b000;
		end else begin
			ack_q <= fire;
			rom_pend_q <= take && core_pm && pm_rom;
			if (take) begin
				{op_pm_q, op_pmd_q, op_we_q} <= {core_pm, core_pm_data, core_we};
				rom_addr_q <= core_addr;
			end
			if (fire)
				rdata_q <= (f_pm && !f_pmd) ? f_word : {8'h00, f_word[23:8]};
		end
	end

	assign bus_grant_n = gnt_n_q;
	assign ext_ctrl_oe = ctrl_oe_q;
	assign ext_addr = addr_q;
	assign ext_data_out = dout_q;
	assign ext_data_oe = doe_q;
	assign program_space_select_n = pms_n_q;
	assign data_space_select_n = dms_n_q;
	assign boot_space_select_n = bms_n_q;
	assign ext_rd_n = rd_n_q;
	assign ext_wr_n = wr_n_q;
	assign host_byte_ready = host_rdy_q;
	assign rom_addr = rom_addr_q;
	assign core_ack = ack_q;
	assign core_rdata = rdata_q;
	assign low_byte_extension_reg = px_q;
	assign mode_status_register = mode_status_register_q;
	assign core_hold = hold_q;
	assign run_start = start_q;
	assign run_addr = start_addr_q;
	assign rom_window_enable = ctrl_q[emb_pkg::ROMEN_BIT];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_reset_clear;
		$fell(sys_rst) |-> mode_status_register_q == 7'h00 && hold_q && ctrl_q[8:0] == 9'h1ff;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
	property p_rom_reset;
		$fell(sys_rst) |-> ctrl_q[emb_pkg::ROMEN_BIT] == $past(memory_map_select_s2 && boot_source_select_s2);
	endproperty
	a_rom_reset: assert property (p_rom_reset) else $error("rom window reset wrong");
	property p_rd_qualified;
		!rd_n_q |-> (pms_n_q + dms_n_q + bms_n_q) == 2;
	endproperty
	a_rd_qualified: assert property (p_rd_qualified) else $error("read without one select");
	property p_wr_no_boot;
		!wr_n_q |-> bms_n_q && (pms_n_q != dms_n_q) && rd_n_q;
	endproperty
	a_wr_no_boot: assert property (p_wr_no_boot) else $error("bad write strobe");
	property p_boot_lines;
		!bms_n_q |-> doe_q == 24'hc0_0000 && dout_q[23:22] == boot_addr[15:14];
	endproperty
	a_boot_lines: assert property (p_boot_lines) else $error("boot lines wrong");
	property p_strobe_len;
		$fell(rd_n_q) |=> !rd_n_q [*2];
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");
	property p_grant_quiet;
		!gnt_n_q |-> doe_q == 24'h00_0000 && !ctrl_oe_q && !busy_q;
	endproperty
	a_grant_quiet: assert property (p_grant_quiet) else $error("driving while granted");
	property p_map_high_start;
		start_q && memory_map_select_q |-> start_addr_q == (boot_source_select_s2 ? 14'h0800 : 14'h0000);
	endproperty
	a_map_high_start: assert property (p_map_high_start) else $error("bad start address");
	property p_dm_lanes;
		!dms_n_q && !wr_n_q |-> doe_q == 24'hff_ff00;
	endproperty
	a_dm_lanes: assert property (p_dm_lanes) else $error("data lanes wrong");
	c_boot_done: cover property (in_boot ##1 start_q);
	c_grant: cover property ($fell(gnt_n_q));
	c_ext_read: cover property ($fell(pms_n_q) ##[1:20] ack_q);
	c_rom_read: cover property (rom_pend_q ##1 ack_q);
endmodule
`default_nettype wire

/* core/emb_pkg.sv */
`default_nettype none
package emb_pkg;
	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam int PWORD_W = 24;
	localparam int DWORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int IRAM_AW = 11;
	localparam int WAIT_W = 3;
	localparam int PAGE_W = 3;
	localparam int MODE_STATUS_REGISTER_W = 7;
	localparam int BOOT_AW = 16;
	// ---------------------------------------------------------------
	// address map
	// ---------------------------------------------------------------
	localparam logic [13:0] ROM_FIRST = 14'h0800;
	localparam logic [13:0] ROM_LAST = 14'h27ff;
	localparam logic [13:0] PRAM_HI_BASE = 14'h3800;
	localparam logic [13:0] DRAM_BASE = 14'h3000;
	localparam logic [13:0] DREG_BASE = 14'h3800;
	localparam logic [13:0] CTRL_REG_ADDR = 14'h3ffe;
	localparam logic [13:0] START_RAM = 14'h0000;
	localparam logic [13:0] START_EXT = 14'h0000;
	localparam logic [13:0] START_ROM = 14'h0800;
	// ---------------------------------------------------------------
	// rom_enable_wait_state_control fields
	// ---------------------------------------------------------------
	localparam int PMW_LSB = 0;
	localparam int DMW_LSB = 3;
	localparam int BTW_LSB = 6;
	localparam int PAGE_LSB = 9;
	localparam int FORCE_BIT = 12;
	localparam int ROMEN_BIT = 15;
	localparam logic [15:0] CTRL_RESET = 16'h01ff;
	localparam logic [6:0] MODE_STATUS_REGISTER_RESET = 7'h00;
	// ---------------------------------------------------------------
	// boot and timing
	// ---------------------------------------------------------------
	localparam int BOOT_WORDS = 2048;
	localparam int BYTES_PER_WORD = 3;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] SYNC_EXTRA = 4'h2;
	localparam logic [23:0] BOOT_OE = 24'hc0_0000;
	localparam logic [23:0] DM_OE = 24'hff_ff00;
	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_BOOT = 2'b01,
		ST_RUN = 2'b11
	} emb_state_t;
endpackage
`default_nettype wire

/* bench/emb_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// external program and boot memories
// ---------------------------------------------------------------
module emb_mem_model (
	input wire logic core_clk,
	input wire logic [13:0] ext_addr,
	input wire logic [23:0] ext_data_out,
	input wire logic program_space_select_n,
	input wire logic boot_space_select_n,
	input wire logic ext_rd_n,
	output logic [23:0] ext_data_in
);
	logic [23:0] last_q = 24'h000000;
	logic [15:0] boot_a;
	assign boot_a = {ext_data_out[23:22], ext_addr};
	// an undriven bus shows the inverse of the last value, never a stale copy
	always_comb begin
		if (!ext_rd_n && !boot_space_select_n) begin
			ext_data_in = {8'h00, boot_a[7:0] ^ boot_a[15:8] ^ 8'h5a, 8'h00};
		end else if (!ext_rd_n && !program_space_select_n) begin
			ext_data_in = {2'h0, ext_addr, 8'ha5};
		end else begin
			ext_data_in = ~last_q;
		end
	end
	always_ff @(posedge core_clk) begin
		last_q <= ext_data_in;
	end
endmodule
`default_nettype wire

/* bench/ext_memory_map_and_boot_test.sv */
`timescale 1ns/10ps
`default_nettype none
module ext_memory_map_and_boot_test;
	localparam int BW = 4;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic memory_map_select = 1'b0, boot_source_select = 1'b0, bus_req_n = 1'b1;
	logic core_req = 1'b0, core_pm = 1'b0, core_we = 1'b0, core_pm_data = 1'b0;
	logic [13:0] core_addr = 14'h0000;
	logic [23:0] core_wdata = 24'h000000;
	logic [7:0] host_byte = 8'h00, px_wdata = 8'h00;
	logic host_byte_valid = 1'b0, px_we = 1'b0, mode_status_register_we = 1'b0;
	logic [6:0] mode_status_register_wdata = 7'h00;
	logic bus_grant_n, ext_ctrl_oe, program_space_select_n, data_space_select_n;
	logic boot_space_select_n, ext_rd_n, ext_wr_n, host_byte_ready, core_ack;
	logic core_hold, run_start, rom_window_enable, pms_seen = 1'b0;
	logic [23:0] dmw_q = 24'h000000;
	logic [13:0] ext_addr, rom_addr, run_addr;
	logic [23:0] ext_data_in, ext_data_out, ext_data_oe, rom_word, core_rdata, e;
	logic [7:0] low_byte_extension_reg;
	logic [6:0] mode_status_register;
	logic [15:0] lfsr_q = 16'h1ce4;
	int fails = 0, cmp_count = 0, cyc = 0, hb = 0;
	assign rom_word = {rom_addr, 10'h000};
	emb_ext_mem #(.BOOT_WORDS(BW)) emb_ext_mem_inst (.*);
	emb_mem_model emb_mem_model_inst (.*);
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (!program_space_select_n && !ext_rd_n) pms_seen <= 1'b1;
		if (!data_space_select_n && !ext_wr_n) dmw_q <= ext_data_out & ext_data_oe;
		cyc++;
		if (cyc == 30000) begin
			fails++;
			report_and_stop();
		end
	end
	// host side: a new byte after each accepted one
	always @(posedge core_clk) begin
		if (host_byte_valid && host_byte_ready) hb++;
		#1;
		host_byte = bb(hb + 40);
	end
	// ---------------------------------------------------------------
	// reference values and bus tasks
	// ---------------------------------------------------------------
	function automatic logic [7:0] bb(input int a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	function automatic logic [23:0] pmw(input logic [13:0] a);
		return {2'h0, a, 8'ha5};
	endfunction
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
		cmp_count++;
		if (g !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	// request held until ack, dropped in the ack cycle so it is not retaken
	task automatic acc(input logic pm, we, pd, input logic [13:0] a, input logic [23:0] d);
		int n;
		@(posedge core_clk);
		#1;
		{core_pm, core_we, core_pm_data, core_addr, core_wdata} = {pm, we, pd, a, d};
		core_req = 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (core_ack !== 1'b1 && n < 50);
		core_req = 1'b0;
		chk("ack", 24'h1, {23'h0, core_ack});
	endtask
	task automatic boot(input logic m, s, input logic [13:0] ea, input logic er, rs);
		int n;
		if (rs) begin
			@(posedge core_clk);
			#1;
			sys_rst = 1'b1;
			memory_map_select = m;
			boot_source_select = s;
			repeat (8) @(posedge core_clk);
			#1;
			chk("hold_rst", 24'h1, {23'h0, core_hold});
			sys_rst = 1'b0;
		end
		n = 0;
		while (run_start !== 1'b1 && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("run_start", 24'h1, {23'h0, run_start});
		chk("hold_run", 24'h0, {23'h0, core_hold});
		chk("run_addr", {10'h0, ea}, {10'h0, run_addr});
		chk("rom_win", {23'h0, er}, {23'h0, rom_window_enable});
		chk("mode_status_register", 24'h0, {17'h0, mode_status_register});
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		int i;
		boot(0, 0, 14'h0000, 0, 1);
		for (i = 0; i < BW; i++) begin
			acc(1, 0, 0, i[13:0], 0);
			chk("boot_word", {bb(3 * i), bb(3 * i + 1), bb(3 * i + 2)}, core_rdata);
		end
		acc(0, 0, 0, 14'h3ffe, 0);
		chk("ctrl_reset", 24'h0001ff, core_rdata);
		acc(0, 1, 0, 14'h3ffe, 24'h0001f8);
		acc(0, 0, 0, 14'h3ffe, 0);
		chk("ctrl_rw", 24'h0001f8, core_rdata);
		for (i = 0; i < 4; i++) begin
			lfsr_q = nx(lfsr_q);
			acc(0, 1, 0, 14'h3000 + i[13:0], {8'h00, lfsr_q});
			acc(0, 0, 0, 14'h3000 + i[13:0], 0);
			chk("dram", {8'h00, lfsr_q}, core_rdata);
		end
		acc(0, 0, 0, 14'h3800, 0);
		chk("reserved", 24'h0, core_rdata);
		acc(1, 0, 0, 14'h1000, 0);
		chk("ext_pm", pmw(14'h1000), core_rdata);
		chk("pms_seen", 24'h1, {23'h0, pms_seen});
		acc(1, 0, 1, 14'h1001, 0);
		e = pmw(14'h1001);
		chk("pmd_rd", {8'h00, e[23:8]}, core_rdata);
		chk("px", {16'h0, e[7:0]}, {16'h0, low_byte_extension_reg});
		acc(0, 1, 0, 14'h3ffe, 24'h001c38);
		boot(0, 0, 14'h0000, 0, 0);
		for (i = 0; i < BW; i++) begin
			acc(1, 0, 0, i[13:0], 0);
			e = {bb(32'hc000 + 3 * i), bb(32'hc001 + 3 * i), bb(32'hc002 + 3 * i)};
			chk("page_word", e, core_rdata);
		end
		acc(0, 0, 0, 14'h3ffe, 0);
		chk("force_clr", 24'h000c38, core_rdata);
		acc(0, 1, 0, 14'h0100, {8'h00, lfsr_q});
		chk("dm_bus", {lfsr_q, 8'h00}, dmw_q);
		@(posedge core_clk);
		#1;
		{px_we, px_wdata, mode_status_register_we, mode_status_register_wdata} = {1'b1, lfsr_q[7:0], 1'b1, 7'h55};
		@(posedge core_clk);
		#1;
		{px_we, mode_status_register_we} = 2'b00;
		acc(1, 1, 1, 14'h0010, 24'h00beef);
		acc(1, 0, 0, 14'h0010, 0);
		chk("pm_wr", {16'hbeef, lfsr_q[7:0]}, core_rdata);
		chk("mode_status_register_wr", 24'h55, {17'h0, mode_status_register});
		@(posedge core_clk);
		#1;
		bus_req_n = 1'b0;
		i = 0;
		while (bus_grant_n !== 1'b0 && i < 20) begin
			@(posedge core_clk);
			#1;
			i++;
		end
		chk("grant_oe", 24'h0, {22'h0, bus_grant_n, ext_ctrl_oe});
		bus_req_n = 1'b1;
		host_byte_valid = 1'b1;
		repeat (6) @(posedge core_clk);
		boot(0, 1, 14'h0000, 0, 1);
		host_byte_valid = 1'b0;
		for (i = 0; i < BW; i++) begin
			acc(1, 0, 0, i[13:0], 0);
			e = {bb(3 * i + 40), bb(3 * i + 41), bb(3 * i + 42)};
			chk("host_word", e, core_rdata);
		end
		boot(1, 1, 14'h0800, 1, 1);
		acc(1, 0, 0, 14'h0900, 0);
		chk("rom", {14'h0900, 10'h000}, core_rdata);
		boot(1, 0, 14'h0000, 0, 1);
		acc(1, 0, 0, 14'h0900, 0);
		chk("rom_off", pmw(14'h0900), core_rdata);
		report_and_stop();
	end
endmodule
`default_nettype wire
